// >>> sdl_code_latch.v
`include "sdl_defines.vh"

// Holding latch for the converter code; read data out of a register
module sdl_code_latch (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [`SDL_CODE_MSB:0] load_data,
  output reg [`SDL_CODE_MSB:0] code_r
);

  always @(posedge clk) begin
    if (rst) begin
      code_r <= `SDL_CODE_RST;
    end else if (load) begin
      code_r <= load_data;
    end
  end

endmodule // sdl_code_latch

// >>> sdl_defines.vh
`ifndef SDL_DEFINES_VH
`define SDL_DEFINES_VH

// Word layout
`define SDL_WORD_BITS 16
`define SDL_CODE_BITS 12
`define SDL_CODE_MSB 11
`define SDL_CNT_BITS 5
`define SDL_CNT_FULL 5'h10
`define SDL_CNT_ZERO 5'h00

// Reset values
`define SDL_SHIFT_RST 16'h0000
`define SDL_CODE_RST 12'h000

// Synchroniser depth
`define SDL_SYNC_STAGES 2

`endif

// >>> sdl_host_model.sv
module sdl_host_model (
  output logic sclk,
  output logic sdat,
  output logic fsel_n,
  output logic latch_load_n_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 0;
    sdat = 0;
    fsel_n = 1;
    latch_load_n_n = 0;
  end
  // Clock idles low; data flips after frame
  task send(input logic [15:0] w, input int n, input logic strobed);
    latch_load_n_n = strobed;
    #40 fsel_n = 0;
    #100;
    for (int i = 0; i < n; i++) begin
      sclk = 1;
      sdat = i < 16 ? w[15 - i] : ~sdat;
      #80 sclk = 0;
      #80;
    end
    #80 fsel_n = 1;
    sdat = ~sdat;
  endtask
  task strobe();
    latch_load_n_n = 0;
    #100 latch_load_n_n = 1;
  endtask
endmodule // sdl_host_model

// >>> sdl_loader.v
// Behaviour
// - Data pin shifted in on each falling shift-clock edge during a frame
// - A transfer is one sixteen-bit word
// - Frame select falling clears counter and input logic for a new word
// - Counter gates clock: exactly sixteen bits taken, later edges ignored
// - First four bits dropped, last twelve go to the latch
// - Word sent MSB first, code LSB is the final bit
// - Output follows only the latch, never the shift register
// - Load strobe level sampled when frame select falls picks update mode
// - Strobe low: latch loads on sixteenth falling shift-clock edge
// - Strobe high: latch loads on next falling edge of the strobe
// - Code is two's complement, zero means midscale
`include "sdl_defines.vh"

module sdl_loader (
  input wire clk,
  input wire rst,
  input wire serial_shift_clock,
  input wire serial_data_input,
  input wire frame_select_n,
  input wire latch_load_n,
  output reg [`SDL_CODE_MSB:0] analog_output,
  output reg word_ready,
  output reg auto_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire sclk_s;
  wire sclk_p;
  wire serial_data_input_s;
  wire serial_data_input_p;
  wire fsel_s;
  wire fsel_p;
  wire load_s;
  wire load_p;

  sdl_sync u_sclk (
    .clk(clk),
    .rst(rst),
    .pin_in(serial_shift_clock),
    .pin_rst_val(1'b0),
    .pin_sync_r(sclk_s),
    .pin_prev_r(sclk_p)
  );

  sdl_sync u_serial_data_input (
    .clk(clk),
    .rst(rst),
    .pin_in(serial_data_input),
    .pin_rst_val(1'b0),
    .pin_sync_r(serial_data_input_s),
    .pin_prev_r(serial_data_input_p)
  );

  sdl_sync u_fsel (
    .clk(clk),
    .rst(rst),
    .pin_in(frame_select_n),
    .pin_rst_val(1'b1),
    .pin_sync_r(fsel_s),
    .pin_prev_r(fsel_p)
  );

  sdl_sync u_load (
    .clk(clk),
    .rst(rst),
    .pin_in(latch_load_n),
    .pin_rst_val(1'b0),
    .pin_sync_r(load_s),
    .pin_prev_r(load_p)
  );

  // Edge events in the system clock
  wire sclk_fall;
  wire fsel_fall;
  wire load_fall;
  assign sclk_fall = sclk_p & ~sclk_s;
  assign fsel_fall = fsel_p & ~fsel_s;
  assign load_fall = load_p & ~load_s;

  ////////////////////////////////////////////////////////////////////////
  // Frame state

  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`SDL_WORD_BITS-1:0] shift_r;
  reg [`SDL_WORD_BITS-1:0] shift_nxt;
  reg [`SDL_CNT_BITS-1:0] cnt_r;
  reg [`SDL_CNT_BITS-1:0] cnt_nxt;
  reg auto_r;
  reg auto_nxt;
  reg pend_r;
  reg pend_nxt;
  reg load_now;
  reg [`SDL_CODE_MSB:0] load_data;

  function [`SDL_CODE_MSB:0] code_of;
    input [`SDL_WORD_BITS-1:0] word;
    begin
      code_of = word[`SDL_CODE_MSB:0];
    end
  endfunction

  always @* begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    auto_nxt = auto_r;
    pend_nxt = pend_r;
    load_now = 1'b0;
    load_data = code_of(shift_r);
    case (state_r)
      ST_IDLE: begin
        if (fsel_fall) begin
          state_nxt = ST_SHIFT;
          cnt_nxt = `SDL_CNT_ZERO;
          shift_nxt = `SDL_SHIFT_RST;
          pend_nxt = 1'b0;
          auto_nxt = ~load_s;
        end else if (pend_r && load_fall) begin
          load_now = 1'b1;
          pend_nxt = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (fsel_s) begin
          state_nxt = ST_IDLE;
        end else if (sclk_fall) begin
          shift_nxt = {shift_r[`SDL_WORD_BITS-2:0], serial_data_input_p};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `SDL_CNT_FULL - 5'h01) begin
            state_nxt = ST_DONE;
            if (auto_r) begin
              load_now = 1'b1;
              load_data = code_of({shift_r[`SDL_WORD_BITS-2:0], serial_data_input_p});
            end else begin
              pend_nxt = 1'b1;
            end
          end
        end
      end
      ST_DONE: begin
        // Further shift-clock edges locked out
        if (fsel_s) begin
          state_nxt = ST_IDLE;
        end
        if (pend_r && load_fall) begin
          load_now = 1'b1;
          pend_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      shift_r <= `SDL_SHIFT_RST;
      cnt_r <= `SDL_CNT_ZERO;
      auto_r <= 1'b0;
      pend_r <= 1'b0;
      word_ready <= 1'b0;
      auto_mode <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      auto_r <= auto_nxt;
      pend_r <= pend_nxt;
      word_ready <= pend_nxt;
      auto_mode <= auto_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter latch and output

  wire [`SDL_CODE_MSB:0] code_q;

  sdl_code_latch u_latch (
    .clk(clk),
    .rst(rst),
    .load(load_now),
    .load_data(load_data),
    .code_r(code_q)
  );

  always @(posedge clk) begin
    if (rst) begin
      analog_output <= `SDL_CODE_RST;
    end else begin
      analog_output <= code_q;
    end
  end

  wire serial_data_input_unused;
  assign serial_data_input_unused = serial_data_input_s;

endmodule // sdl_loader

// >>> sdl_loader_asserts.sv
`include "sdl_defines.vh"
module sdl_loader_asserts (
  input wire clk,
  input wire rst,
  input wire frame_select_n,
  input wire latch_load_n,
  input wire [`SDL_CODE_MSB:0] analog_output,
  input wire word_ready,
  input wire auto_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    analog_output == 0 && !word_ready && !auto_mode) else $error("reset state");
  a_mode_auto: assert property ($fell(frame_select_n) && !latch_load_n |-> ##8 auto_mode)
    else $error("auto mode");
  a_mode_strobed: assert property ($fell(frame_select_n) && latch_load_n |-> ##8 !auto_mode)
    else $error("strobed mode");
  a_frame_clear: assert property ($fell(frame_select_n) |-> ##8 !word_ready)
    else $error("frame clear");
  a_strobe_drop: assert property (word_ready && $fell(latch_load_n) |-> ##[3:8] !word_ready)
    else $error("ready drop");
  a_strobe_only: assert property ($changed(analog_output) && !auto_mode |->
    !$past(latch_load_n, 3)) else $error("load without strobe");
  a_auto_in_frame: assert property ($changed(analog_output) && auto_mode |->
    !$past(frame_select_n, 6)) else $error("auto load outside frame");
  a_ready_in_frame: assert property ($rose(word_ready) |-> !$past(frame_select_n, 4))
    else $error("ready outside frame");
  c_auto: cover property ($rose(auto_mode));
  c_ready: cover property ($rose(word_ready));
  c_load: cover property ($changed(analog_output));
endmodule // sdl_loader_asserts

// >>> sdl_sync.v
// Two-flop synchroniser for one pin, with a registered copy for edge finding
module sdl_sync (
  input wire clk,
  input wire rst,
  input wire pin_in,
  input wire pin_rst_val,
  output reg pin_sync_r,
  output reg pin_prev_r
);

  reg meta_r;

  always @(posedge clk) begin
    if (rst) begin
      meta_r <= pin_rst_val;
      pin_sync_r <= pin_rst_val;
      pin_prev_r <= pin_rst_val;
    end else begin
      meta_r <= pin_in;
      pin_sync_r <= meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

endmodule // sdl_sync

// >>> testbench.sv
`include "sdl_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst = 1;
  wire sclk, sdat, fsel_n, latch_load_n_n, ready, amode;
  wire [`SDL_CODE_MSB:0] dac;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] w [3] = '{16'hA7FF, 16'h5800, 16'hF000};
  always #10 clk = ~clk;
  sdl_host_model sdl_host_model_inst (.sclk(sclk), .sdat(sdat), .fsel_n(fsel_n),
    .latch_load_n_n(latch_load_n_n));
  sdl_loader sdl_loader_inst (.clk(clk), .rst(rst), .serial_shift_clock(sclk),
    .serial_data_input(sdat), .frame_select_n(fsel_n), .latch_load_n(latch_load_n_n),
    .analog_output(dac), .word_ready(ready), .auto_mode(amode));
  task summarize();
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task settle();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task t_auto();
    foreach (w[i]) begin
      sdl_host_model_inst.send(w[i], 16, 0);
      settle();
      chk(dac, w[i][11:0], "auto code");
      chk(amode, 1, "auto mode");
    end
  endtask
  task t_strobe();
    sdl_host_model_inst.send(16'h0ABC, 16, 1);
    settle();
    chk(dac, 12'h000, "held code");
    chk(ready, 1, "ready");
    chk(amode, 0, "strobed mode");
    sdl_host_model_inst.strobe();
    settle();
    chk(dac, 12'hABC, "strobed code");
    chk(ready, 0, "ready cleared");
  endtask
  task t_abort();
    sdl_host_model_inst.send(16'h0555, 9, 0);
    settle();
    chk(dac, 12'hABC, "short frame");
  endtask
  task t_lockout();
    sdl_host_model_inst.send(16'h3456, 20, 0);
    settle();
    chk(dac, 12'h456, "extra edges");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    settle();
    chk(dac, 0, "reset code");
    t_auto();
    t_strobe();
    t_abort();
    t_lockout();
    summarize();
  end
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule // testbench
bind sdl_loader sdl_loader_asserts sdl_loader_asserts_inst (.clk(clk), .rst(rst),
  .frame_select_n(frame_select_n), .latch_load_n(latch_load_n),
  .analog_output(analog_output), .word_ready(word_ready), .auto_mode(auto_mode));
